//--- logic/pdmi_params.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the top module only
`ifndef PDMI_PARAMS_SVH
`define PDMI_PARAMS_SVH
`define PDMI_OFS_START     12'h000
`define PDMI_OFS_STOP      12'h004
`define PDMI_OFS_EV_START  12'h100
`define PDMI_OFS_EV_STOP   12'h104
`define PDMI_OFS_EV_END    12'h108
`define PDMI_OFS_IRQ_EN    12'h300
`define PDMI_OFS_IRQ_SET   12'h304
`define PDMI_OFS_IRQ_CLR   12'h308
`define PDMI_OFS_ENABLE    12'h500
`define PDMI_OFS_CLKCTRL   12'h504
`define PDMI_OFS_MODE      12'h508
`define PDMI_OFS_GAIN_L    12'h518
`define PDMI_OFS_GAIN_R    12'h51c
`define PDMI_OFS_PSEL_CLK  12'h540
`define PDMI_OFS_PSEL_DIN  12'h544
`define PDMI_OFS_PTR       12'h560
`define PDMI_OFS_MAXCNT    12'h564
`define PDMI_CLK_DIV32     32'h08000000
`define PDMI_CLK_DIV31     32'h08400000
`define PDMI_CLK_DIV30     32'h08800000
`define PDMI_RST_CLKCTRL   32'h08400000
`define PDMI_RST_PSEL      32'hffffffff
`define PDMI_GAIN_FLOOR    7'h00
`define PDMI_GAIN_NOMINAL  7'h28
`define PDMI_GAIN_CEILING  7'h50
`define PDMI_BIT_OPER      0
`define PDMI_BIT_EDGE      1
`define PDMI_BIT_CONNECT   31
`define PDMI_DECIM         64
`define PDMI_PCLK_MHZ      250
`define PDMI_REF_MHZ       32
`endif

//--- logic/pdmi_pkg.sv
// types shared by the microphone interface
// assumes pdmi_params.svh for the numeric constants
package pdmi_pkg;
    typedef enum logic [1:0]
    {
        PDMI_IDLE  = 2'b00,
        PDMI_RUN   = 2'b01,
        PDMI_DRAIN = 2'b11
    } pdmi_state_t;

    typedef struct packed
    {
        logic        req;
        logic [31:0] addr;
        logic [31:0] data;
    } pdmi_dma_req_t;
endpackage

//--- logic/pdmi_top.sv
// pdm microphone receiver: clock generator, sampling, decimation, gain,
// word packing and a single-word dma write port behind an apb slave.
// assumes the pin mux outside honours clk_pin/din_pin and that the dma
// port accepts a word when dma_ack is high.
// Notes on behaviour
// - default: left on falling, right on rising
// - route clock and data via pin selects
// - pin selects only matter while enabled
// - start task begins, stop task requests end
// - started and stopped events raised
// - end event after last sample written
// - irq enable bits started, stopped, end
// - set register: write one enables
// - clear register: write one disables
// - clock control selects divide 32/31/30
// - stereo: right high half, left low
// - mono: earlier left low, later high
// - edge bit swaps sampling edges
// - left gain linear steps of 3/2 in the multiplier, nominal 0x28
// - pin select: number low, connect bit31
// - dma pointer register, resets zero
// - max count gives buffer length
// - enable register gates interface and pins
// - decimate by 64 to 16-bit samples
// - stop waits for the next dma word written, then stopped
// - pointer double-buffered, restart on fill
// - max count counts 16-bit samples
`timescale 1ns/1ps
`include "pdmi_params.svh"
module pdmi_top
    import pdmi_pkg::*;
#(
    parameter int CNT_W = 15
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             mic_bit_clock,
    output logic             mic_bit_clock_oe,
    output logic      [4:0]  clk_pin,
    output logic             clk_pin_en,
    output logic      [4:0]  din_pin,
    output logic             din_pin_en,
    input  wire logic        mic_data,
    output pdmi_dma_req_t    dma,
    input  wire logic        dma_ack
);
    localparam int PERIOD_NUM = `PDMI_PCLK_MHZ;
    localparam int DECIM      = `PDMI_DECIM;

    logic [2:0]  ev_r;
    logic [2:0]  irq_enable_r;
    logic        enable_r;
    logic [31:0] clkctrl_r;
    logic [1:0]  mode_r;
    logic [6:0]  gain_l_r;
    logic [6:0]  gain_r_r;
    logic [31:0] psel_clk_r;
    logic [31:0] psel_din_r;
    logic [31:0] ptr_r;
    logic [CNT_W-1:0] maxcnt_r;
    pdmi_state_t state_r;

    logic wr;
    logic rd_err;
    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & rd_err;

    logic start_t;
    logic stop_t;
    assign start_t = wr && paddr == `PDMI_OFS_START && enable_r;
    assign stop_t  = wr && paddr == `PDMI_OFS_STOP;

    // event sources from the datapath
    logic ev_started;
    logic ev_stopped;
    logic ev_end;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_enable_r    <= 3'h0;
            enable_r   <= 1'b0;
            clkctrl_r  <= `PDMI_RST_CLKCTRL;
            mode_r     <= 2'h0;
            gain_l_r   <= `PDMI_GAIN_NOMINAL;
            gain_r_r   <= `PDMI_GAIN_NOMINAL;
            psel_clk_r <= `PDMI_RST_PSEL;
            psel_din_r <= `PDMI_RST_PSEL;
            ptr_r      <= 32'h0;
            maxcnt_r   <= '0;
        end
        else if (wr)
        begin
            if (paddr == `PDMI_OFS_IRQ_EN)
                irq_enable_r <= pwdata[2:0];
            else if (paddr == `PDMI_OFS_IRQ_SET)
                irq_enable_r <= irq_enable_r | pwdata[2:0];
            else if (paddr == `PDMI_OFS_IRQ_CLR)
                irq_enable_r <= irq_enable_r & ~pwdata[2:0];
            else if (paddr == `PDMI_OFS_ENABLE)
                enable_r <= pwdata[0];
            else if (paddr == `PDMI_OFS_CLKCTRL)
                clkctrl_r <= pwdata;
            else if (paddr == `PDMI_OFS_MODE)
                mode_r <= pwdata[1:0];
            else if (paddr == `PDMI_OFS_GAIN_L)
                gain_l_r <= pwdata[6:0];
            else if (paddr == `PDMI_OFS_GAIN_R)
                gain_r_r <= pwdata[6:0];
            else if (paddr == `PDMI_OFS_PSEL_CLK)
                psel_clk_r <= {pwdata[31], 26'h0, pwdata[4:0]};
            else if (paddr == `PDMI_OFS_PSEL_DIN)
                psel_din_r <= {pwdata[31], 26'h0, pwdata[4:0]};
            else if (paddr == `PDMI_OFS_PTR)
                ptr_r <= pwdata;
            else if (paddr == `PDMI_OFS_MAXCNT)
                maxcnt_r <= pwdata[CNT_W-1:0];
        end
    end

    // sticky events: hardware set wins over software clear
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    assign ev_set = {ev_end, ev_stopped, ev_started};
    assign ev_clr[0] = wr && paddr == `PDMI_OFS_EV_START && !pwdata[0];
    assign ev_clr[1] = wr && paddr == `PDMI_OFS_EV_STOP && !pwdata[0];
    assign ev_clr[2] = wr && paddr == `PDMI_OFS_EV_END && !pwdata[0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_r <= 3'h0;
        else
            ev_r <= ev_set | (ev_r & ~ev_clr);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(ev_r & irq_enable_r);
    end

    always_comb
    begin
        prdata = 32'h0;
        rd_err = 1'b0;
        if (paddr == `PDMI_OFS_EV_START)
            prdata = {31'h0, ev_r[0]};
        else if (paddr == `PDMI_OFS_EV_STOP)
            prdata = {31'h0, ev_r[1]};
        else if (paddr == `PDMI_OFS_EV_END)
            prdata = {31'h0, ev_r[2]};
        else if (paddr == `PDMI_OFS_IRQ_EN || paddr == `PDMI_OFS_IRQ_SET ||
                 paddr == `PDMI_OFS_IRQ_CLR)
            prdata = {29'h0, irq_enable_r};
        else if (paddr == `PDMI_OFS_ENABLE)
            prdata = {31'h0, enable_r};
        else if (paddr == `PDMI_OFS_CLKCTRL)
            prdata = clkctrl_r;
        else if (paddr == `PDMI_OFS_MODE)
            prdata = {30'h0, mode_r};
        else if (paddr == `PDMI_OFS_GAIN_L)
            prdata = {25'h0, gain_l_r};
        else if (paddr == `PDMI_OFS_GAIN_R)
            prdata = {25'h0, gain_r_r};
        else if (paddr == `PDMI_OFS_PSEL_CLK)
            prdata = psel_clk_r;
        else if (paddr == `PDMI_OFS_PSEL_DIN)
            prdata = psel_din_r;
        else if (paddr == `PDMI_OFS_PTR)
            prdata = ptr_r;
        else if (paddr == `PDMI_OFS_MAXCNT)
            prdata = {{(32-CNT_W){1'b0}}, maxcnt_r};
        else if (paddr == `PDMI_OFS_START || paddr == `PDMI_OFS_STOP)
            prdata = 32'h0;
        else
            rd_err = 1'b1;
    end

    // pin routing, only while enabled
    assign clk_pin    = psel_clk_r[4:0];
    assign din_pin    = psel_din_r[4:0];
    assign clk_pin_en = enable_r & ~psel_clk_r[`PDMI_BIT_CONNECT];
    assign din_pin_en = enable_r & ~psel_din_r[`PDMI_BIT_CONNECT];

    // microphone clock: pclk cycles per half period scaled from 32 MHz ref
    logic [5:0] ref_div;
    always_comb
    begin
        if (clkctrl_r == `PDMI_CLK_DIV32)
            ref_div = 6'd32;
        else if (clkctrl_r == `PDMI_CLK_DIV30)
            ref_div = 6'd30;
        else
            ref_div = 6'd31;
    end

    logic [15:0] half_cnt;
    assign half_cnt = 16'((ref_div * PERIOD_NUM) / (2 * `PDMI_REF_MHZ));

    logic [15:0] div_cnt_r;
    logic        clk_q_r;
    logic        running;
    logic        edge_hit;
    assign running  = state_r != PDMI_IDLE;
    assign edge_hit = running && div_cnt_r >= half_cnt - 16'd1;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_r <= 16'h0;
            clk_q_r   <= 1'b0;
        end
        else if (!running)
        begin
            div_cnt_r <= 16'h0;
            clk_q_r   <= 1'b0;
        end
        else if (edge_hit)
        begin
            div_cnt_r <= 16'h0;
            clk_q_r   <= ~clk_q_r;
        end
        else
            div_cnt_r <= div_cnt_r + 16'd1;
    end
    assign mic_bit_clock    = clk_q_r;
    assign mic_bit_clock_oe = clk_pin_en;

    // sample data at the end of each half period, before the edge
    logic fall_s;
    logic rise_s;
    assign fall_s = edge_hit & clk_q_r;
    assign rise_s = edge_hit & ~clk_q_r;
    logic take_l;
    logic take_r;
    assign take_l = mode_r[`PDMI_BIT_EDGE] ? rise_s : fall_s;
    assign take_r = mode_r[`PDMI_BIT_EDGE] ? fall_s : rise_s;
    logic din;
    assign din = mic_data & din_pin_en;

    // boxcar decimator per channel: 64 bits to a signed 16-bit sample
    logic [6:0]  acc_l_r;
    logic [6:0]  acc_r_r;
    logic [5:0]  bit_cnt_r;
    logic        frame_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_l_r   <= 7'h0;
            acc_r_r   <= 7'h0;
            bit_cnt_r <= 6'h0;
            frame_r   <= 1'b0;
        end
        else
        begin
            frame_r <= 1'b0;
            if (!running)
            begin
                acc_l_r   <= 7'h0;
                acc_r_r   <= 7'h0;
                bit_cnt_r <= 6'h0;
            end
            else if (frame_r)
            begin
                acc_l_r <= 7'h0;
                acc_r_r <= 7'h0;
            end
            else
            begin
                if (take_l)
                    acc_l_r <= acc_l_r + {6'h0, din};
                if (take_r)
                begin
                    acc_r_r <= acc_r_r + {6'h0, din};
                    bit_cnt_r <= bit_cnt_r + 6'd1;
                    frame_r <= bit_cnt_r == 6'(DECIM - 1);
                end
            end
        end
    end

    // gain: value = (ones-64) << 8 scaled by a linear multiplier (16 + g*3/2) / 64
    function automatic logic [15:0] apply_gain(input logic [6:0] ones,
                                               input logic [6:0] g);
        logic signed [15:0] base;
        logic signed [23:0] prod;
        logic        [7:0]  mult;
        base = 16'(signed'({1'b0, ones, 8'h0}) - 16'sh4000);
        mult = 8'(16 + 16'(g) * 16'd3 / 16'd2);
        prod = 24'(base) * signed'({16'h0, mult});
        return prod[21:6];
    endfunction

    logic [15:0] smp_l;
    logic [15:0] smp_r;
    assign smp_l = apply_gain(acc_l_r, gain_l_r);
    assign smp_r = apply_gain(acc_r_r, gain_r_r);

    // packing, dma and run control
    logic [31:0] cur_ptr_r;
    logic [CNT_W-1:0] done_r;
    logic [15:0] hold_r;
    logic        half_r;
    logic        stop_req_r;
    pdmi_dma_req_t dma_r;
    assign dma = dma_r;

    logic word_done;
    logic [CNT_W-1:0] done_nxt;
    assign word_done = dma_r.req & dma_ack;
    assign done_nxt  = done_r + CNT_W'(2);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r    <= PDMI_IDLE;
            cur_ptr_r  <= 32'h0;
            done_r     <= '0;
            hold_r     <= 16'h0;
            half_r     <= 1'b0;
            stop_req_r <= 1'b0;
            dma_r      <= '0;
            ev_started <= 1'b0;
            ev_stopped <= 1'b0;
            ev_end     <= 1'b0;
        end
        else
        begin
            ev_started <= 1'b0;
            ev_stopped <= 1'b0;
            ev_end     <= 1'b0;
            if (stop_t && running)
                stop_req_r <= 1'b1;
            case (state_r)
                PDMI_IDLE:
                begin
                    if (start_t)
                    begin
                        state_r    <= PDMI_RUN;
                        cur_ptr_r  <= ptr_r;
                        done_r     <= '0;
                        half_r     <= 1'b0;
                        stop_req_r <= 1'b0;
                        ev_started <= 1'b1;
                    end
                end
                PDMI_RUN:
                begin
                    if (frame_r && !dma_r.req)
                    begin
                        if (mode_r[`PDMI_BIT_OPER] && !half_r)
                        begin
                            hold_r <= smp_l;
                            half_r <= 1'b1;
                        end
                        else
                        begin
                            dma_r.req  <= 1'b1;
                            dma_r.addr <= cur_ptr_r +
                                          32'({done_r, 1'b0});
                            dma_r.data <= mode_r[`PDMI_BIT_OPER] ?
                                          {smp_l, hold_r} :
                                          {smp_r, smp_l};
                            half_r <= 1'b0;
                        end
                    end
                    if (word_done)
                    begin
                        dma_r.req <= 1'b0;
                        done_r    <= done_nxt;
                        if (done_nxt >= maxcnt_r || stop_req_r)
                        begin
                            ev_end <= 1'b1;
                            done_r <= '0;
                            cur_ptr_r <= ptr_r;
                            if (stop_req_r || stop_t)
                                state_r <= PDMI_DRAIN;
                            else
                                ev_started <= 1'b1;
                        end
                    end
                end
                PDMI_DRAIN:
                begin
                    state_r    <= PDMI_IDLE;
                    stop_req_r <= 1'b0;
                    ev_stopped <= 1'b1;
                end
                default:
                    state_r <= PDMI_IDLE;
            endcase
        end
    end
endmodule

//--- verif/pdmi_chk.sv
// concurrent checks on the microphone interface ports
// assumes binding onto pdmi_top with apb answering at once
`timescale 1ns/1ps
module pdmi_chk
    import pdmi_pkg::*;
(
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pslverr,
    input wire logic          irq,
    input wire logic          mic_bit_clock,
    input wire logic          clk_pin_en,
    input wire logic          din_pin_en,
    input wire pdmi_dma_req_t dma,
    input wire logic          dma_ack
);
    logic       wr;
    logic       rd;
    logic       en_r;
    logic       cd_r;
    logic       dd_r;
    logic [2:0] ie_r;
    logic [7:0] hc_r;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // shadow of the configuration written over apb
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_r <= 1'b0;
            cd_r <= 1'b1;
            dd_r <= 1'b1;
            ie_r <= 3'h0;
        end
        else if (wr)
        begin
            case (paddr)
                12'h500: en_r <= pwdata[0];
                12'h540: cd_r <= pwdata[31];
                12'h544: dd_r <= pwdata[31];
                12'h300: ie_r <= pwdata[2:0];
                12'h304: ie_r <= ie_r | pwdata[2:0];
                12'h308: ie_r <= ie_r & ~pwdata[2:0];
                default: ;
            endcase
        end
    end
    // cycles since the last mic clock change, parked at 0xc8
    // also parked after a low phase longer than one half period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hc_r <= 8'hc8;
        else if ($changed(mic_bit_clock))
            hc_r <= 8'h00;
        else if (!mic_bit_clock && hc_r == 8'h79)
            hc_r <= 8'hc8;
        else if (hc_r != 8'hc8)
            hc_r <= hc_r + 8'h01;
    end
    clk_pin_gate_a: assert property
        (clk_pin_en == (en_r && !cd_r)) else $error("clock pin enable");
    din_pin_gate_a: assert property
        (din_pin_en == (en_r && !dd_r)) else $error("data pin enable");
    clk_quiet_a: assert property
        (!en_r && !$past(en_r) |-> !mic_bit_clock) else $error("clk idle");
    irq_masked_a: assert property
        (ie_r == 3'h0 && $past(ie_r) == 3'h0 |-> !irq)
        else $error("irq while masked");
    dma_hold_a: assert property
        (dma.req && !dma_ack |=> dma.req && $stable(dma.addr)
            && $stable(dma.data)) else $error("dma request moved");
    clk_half_a: assert property
        ($changed(mic_bit_clock) && hc_r != 8'hc8 |->
            (mic_bit_clock ? hc_r == 8'h78 : hc_r <= 8'h78))
        else $error("mic clock half period");
    rd_irq_en_a: assert property
        (rd && paddr inside {12'h300, 12'h304, 12'h308}
            |-> prdata == {29'h0, ie_r}) else $error("irq enable read");
    rd_enable_a: assert property
        (rd && paddr == 12'h500 |-> prdata == {31'h0, en_r})
        else $error("enable read");
    cover property ($rose(dma.req));
    cover property ($rose(irq));
    cover property (rd && pslverr);
endmodule
bind pdmi_top pdmi_chk pdmi_chk_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .mic_bit_clock(mic_bit_clock), .clk_pin_en(clk_pin_en),
    .din_pin_en(din_pin_en), .dma(dma), .dma_ack(dma_ack));

//--- verif/pdmi_mic_model.sv
// stereo pair of pdm microphones on one data line
// assumes the clock comes from the interface and sel is the data route
`timescale 1ns/1ps
module pdmi_mic_model
(
    input  wire logic pclk,
    input  wire logic clk_in,
    input  wire logic sel,
    output logic      dout
);
    logic tog_r = 1'b0;
    logic lvl;
    // left mic sends ones while clock high, right zeros while low
    assign #20 lvl = clk_in;
    // unrouted line wanders so a stale value never looks valid
    always @(posedge pclk) tog_r <= ~tog_r;
    assign dout = sel ? lvl : tog_r;
endmodule

//--- verif/tb_top.sv
// self-checking bench for the microphone interface
// assumes pdmi_top, pdmi_chk bound to it and the mic model
`timescale 1ns/1ps
module tb_top
    import pdmi_pkg::*;
;
    localparam logic [11:0] RA [0:13] = '{12'h100, 12'h104, 12'h108,
        12'h300, 12'h304, 12'h308, 12'h500, 12'h504, 12'h508, 12'h518,
        12'h51c, 12'h540, 12'h544, 12'h560};
    localparam logic [31:0] RV [0:13] = '{32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h08400000, 32'h0, 32'h28, 32'h28,
        32'hffffffff, 32'hffffffff, 32'h0};
    localparam logic [11:0] WA [0:5] = '{12'h508, 12'h518, 12'h51c,
        12'h504, 12'h504, 12'h504};
    localparam logic [31:0] WV [0:5] = '{32'h3, 32'h50, 32'h0,
        32'h08800000, 32'h08000000, 32'h08400000};
    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [11:0]   paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          irq;
    logic          mic_bit_clock;
    logic          mic_bit_clock_oe;
    logic [4:0]    clk_pin;
    logic          clk_pin_en;
    logic [4:0]    din_pin;
    logic          din_pin_en;
    logic          mic_data;
    pdmi_dma_req_t dma;
    logic          dma_ack = 1'b0;
    logic [1:0]    st_r = 2'h0;
    logic [31:0]   rd_v;
    logic          er_v;
    int            err_count;
    int            check_count;
    int            cyc = 0;
    pdmi_top pdmi_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .mic_bit_clock(mic_bit_clock),
        .mic_bit_clock_oe(mic_bit_clock_oe), .clk_pin(clk_pin),
        .clk_pin_en(clk_pin_en),
        .din_pin(din_pin), .din_pin_en(din_pin_en), .mic_data(mic_data),
        .dma(dma), .dma_ack(dma_ack));
    pdmi_mic_model pdmi_mic_model_inst (.pclk(pclk),
        .clk_in(mic_bit_clock), .sel(din_pin_en), .dout(mic_data));
    always #2 pclk = ~pclk;
    // ram side stalls four cycles before taking each word
    always @(posedge pclk)
    begin
        st_r <= (dma.req && !dma_ack) ? st_r + 2'h1 : 2'h0;
        dma_ack <= (st_r == 2'h3);
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            err_count = err_count + 1;
            wrap_up;
        end
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count = check_count + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("ERROR %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_v = prdata;
        er_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        @(negedge pclk);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd_v, e);
    endtask
    task automatic wait_ev(input logic [11:0] a);
        rd_v = 32'h0;
        for (int n = 0; n < 20000 && rd_v !== 32'h1; n++)
            apb(1'b0, a, 32'h0);
        rc(a, 32'h1);
    endtask
    task automatic wait_req;
        for (int n = 0; n < 40000 && dma.req !== 1'b1; n++)
            @(posedge pclk);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 14; i++)
            rc(RA[i], RV[i]);
        apb(1'b0, 12'h00c, 32'h0);
        chk({31'h0, er_v}, 32'h1);
        chk(rd_v, 32'h0);
        $display("reset values done");
    endtask
    task automatic t_irq;
        wr(12'h300, 32'h5);
        rc(12'h300, 32'h5);
        wr(12'h304, 32'h2);
        wr(12'h304, 32'h0);
        rc(12'h308, 32'h7);
        wr(12'h308, 32'h1);
        wr(12'h308, 32'h0);
        rc(12'h304, 32'h6);
        wr(12'h308, 32'h7);
        $display("irq enables done");
    endtask
    task automatic t_regs;
        for (int i = 0; i < 6; i++)
        begin
            wr(WA[i], WV[i]);
            rc(WA[i], WV[i]);
        end
        wr(12'h508, 32'h0);
        $display("config registers done");
    endtask
    task automatic t_pins;
        wr(12'h540, 32'h5);
        wr(12'h544, 32'h7);
        chk({31'h0, clk_pin_en}, 32'h0);
        chk({31'h0, mic_bit_clock_oe}, 32'h0);
        wr(12'h500, 32'h1);
        chk({31'h0, clk_pin_en}, 32'h1);
        chk({31'h0, mic_bit_clock_oe}, 32'h1);
        chk({27'h0, clk_pin}, 32'h5);
        chk({27'h0, din_pin}, 32'h7);
        wr(12'h544, 32'h80000007);
        chk({31'h0, din_pin_en}, 32'h0);
        wr(12'h544, 32'h7);
        $display("pin routing done");
    endtask
    task automatic t_stream;
        time t0;
        logic [31:0] d0;
        wr(12'h560, 32'h1000);
        wr(12'h564, 32'h2);
        wr(12'h300, 32'h7);
        wr(12'h000, 32'h1);
        wait_ev(12'h100);
        chk({31'h0, irq}, 32'h1);
        wr(12'h100, 32'h0);
        wr(12'h560, 32'h2000);
        @(posedge mic_bit_clock);
        t0 = $time;
        @(posedge mic_bit_clock);
        chk(32'(($time - t0) / 4), 32'd242);
        wait_req;
        chk(dma.addr, 32'h1000);
        d0 = dma.data;
        chk({31'h0, dma.data[31:16] !== dma.data[15:0]}, 32'h1);
        wait_ev(12'h108);
        wait_ev(12'h100);
        wr(12'h004, 32'h1);
        wait_req;
        chk(dma.addr, 32'h2000);
        wait_ev(12'h104);
        rc(12'h108, 32'h1);
        wr(12'h508, 32'h2);
        wr(12'h560, 32'h3000);
        wr(12'h000, 32'h1);
        wait_req;
        chk(dma.addr, 32'h3000);
        chk({31'h0, dma.data[31:16] !== d0[31:16]}, 32'h1);
        $display("stream done");
    endtask
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        err_count = 0;
        check_count = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_irq;
        t_regs;
        t_pins;
        t_stream;
        wrap_up;
    end
endmodule
